// file: rtl/sar_adc_sequencer.sv
// sar_adc_sequencer: control, timing and byte read path of a 10-bit sar converter
// assumes an 8-bit cpu bus with single-cycle rd/wr strobes and a standby level
`default_nettype none
module sar_adc_sequencer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic standby,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic ext_trigger_in_n,
  input wire logic comp_in,
  output logic [7:0] rdata,
  output logic conversion_end_irq,
  output logic [2:0] analog_sel,
  output logic sample_hold
);
  typedef struct packed {
    logic conversion_end_flag;
    logic conversion_irq_enable;
    logic convert_start_bit;
    logic scan_mode;
    logic conv_time_select;
    logic group_select_bit;
    logic chan_select_hi;
    logic chan_select_lo;
    logic ext_trigger_enable;
    logic flag_seen;
    logic [7:0] temp_latch;
    logic [39:0] results;
    sarseq_pkg::sarseq_state_e state;
    logic [8:0] cnt;
    logic first;
    logic [1:0] pos;
    logic [7:0] rdata;
    logic irq;
    logic [2:0] analog_sel;
    logic sample_hold;
  } sarseq_s;
  sarseq_s q, d;
  logic trig_fall;
  logic [9:0] code;
  logic sar_begin;
  logic sar_step;
  logic [8:0] sync_len;
  logic [8:0] spl_len;
  logic [8:0] total_len;
  logic [1:0] last_pos;
  logic [7:0] csr_val;
  sarseq_sync u_trig (
    .clk(clk),
    .resetn(resetn),
    .d_in(ext_trigger_in_n),
    .fall(trig_fall)
  );
  sarseq_sar u_sar (
    .clk(clk),
    .resetn(resetn),
    .begin_conv(sar_begin),
    .step(sar_step),
    .comp_in(comp_in),
    .code(code)
  );
  assign csr_val = {q.conversion_end_flag, q.conversion_irq_enable, q.convert_start_bit,
                    q.scan_mode, q.conv_time_select, q.group_select_bit,
                    q.chan_select_hi, q.chan_select_lo};
  assign last_pos = {q.chan_select_hi, q.chan_select_lo};
  always_comb begin
    sync_len = q.conv_time_select ? sarseq_pkg::SYNC_FAST_CYC : sarseq_pkg::SYNC_SLOW_CYC;
    spl_len = q.conv_time_select ? sarseq_pkg::SPL_FAST_CYC : sarseq_pkg::SPL_SLOW_CYC;
    if (q.first) begin
      total_len = q.conv_time_select ? sarseq_pkg::FIRST_FAST_CYC
                                     : sarseq_pkg::FIRST_SLOW_CYC;
    end else begin
      // later conversions enter at cnt = sync_len, so the period is counted from there
      total_len = sync_len + (q.conv_time_select ? sarseq_pkg::NEXT_FAST_CYC
                                                 : sarseq_pkg::NEXT_SLOW_CYC);
    end
  end
  // sar steps spread over the convert phase; core begins at sample end
  assign sar_begin = (q.state == sarseq_pkg::SARSEQ_SAMPLE) &&
                     (q.cnt == sync_len + spl_len - 9'd1);
  assign sar_step = (q.state == sarseq_pkg::SARSEQ_CONVERT) && (q.cnt[2:0] == 3'd0);
  always_comb begin
    logic start_req;
    logic stop_req;
    logic conv_done;
    logic [1:0] reg_idx;
    start_req = 1'b0;
    stop_req = 1'b0;
    conv_done = 1'b0;
    reg_idx = 2'd0;
    d = q;
    d.rdata = 8'h00;
    // bus read path
    if (rd) begin
      case (addr)
        sarseq_pkg::ADDR_CSR: begin
          d.rdata = csr_val;
          if (q.conversion_end_flag) begin
            d.flag_seen = 1'b1;
          end
        end
        sarseq_pkg::ADDR_TRG: begin
          d.rdata = {q.ext_trigger_enable, sarseq_pkg::TRG_RSVD_ONES};
        end
        default: begin
          if (addr[3] == 1'b0) begin
            reg_idx = addr[2:1];
            if (addr[0] == 1'b0) begin
              d.rdata = q.results[reg_idx * 10 + 2 +: 8];
              d.temp_latch = {q.results[reg_idx * 10 +: 2], 6'b00_0000};
            end else begin
              d.rdata = q.temp_latch;
            end
          end
        end
      endcase
    end
    // bus write path; settings taken before start so a joint write uses them
    if (wr && addr == sarseq_pkg::ADDR_CSR) begin
      d.conversion_irq_enable = wdata[sarseq_pkg::CSR_IE_BIT];
      d.scan_mode = wdata[sarseq_pkg::CSR_SCAN_BIT];
      d.conv_time_select = wdata[sarseq_pkg::CSR_CKS_BIT];
      d.group_select_bit = wdata[sarseq_pkg::CSR_GROUP_BIT];
      d.chan_select_hi = wdata[1];
      d.chan_select_lo = wdata[0];
      if (!wdata[sarseq_pkg::CSR_FLAG_BIT] && q.flag_seen) begin
        d.conversion_end_flag = 1'b0;
        d.flag_seen = 1'b0;
      end
      if (wdata[sarseq_pkg::CSR_START_BIT] && !q.convert_start_bit) begin
        start_req = 1'b1;
      end else if (!wdata[sarseq_pkg::CSR_START_BIT]) begin
        stop_req = 1'b1;
      end
    end
    if (wr && addr == sarseq_pkg::ADDR_TRG) begin
      d.ext_trigger_enable = wdata[sarseq_pkg::TRG_EN_BIT];
    end
    if (q.ext_trigger_enable && trig_fall && !q.convert_start_bit) begin
      start_req = 1'b1;
    end
    // sequencer
    case (q.state)
      sarseq_pkg::SARSEQ_IDLE: begin
        d.cnt = 9'd0;
      end
      sarseq_pkg::SARSEQ_SYNC: begin
        d.cnt = q.cnt + 9'd1;
        if (q.cnt == sync_len - 9'd1) begin
          d.state = sarseq_pkg::SARSEQ_SAMPLE;
          d.sample_hold = 1'b1;
        end
      end
      sarseq_pkg::SARSEQ_SAMPLE: begin
        d.cnt = q.cnt + 9'd1;
        if (q.cnt == sync_len + spl_len - 9'd1) begin
          d.state = sarseq_pkg::SARSEQ_CONVERT;
          d.sample_hold = 1'b0;
        end
      end
      sarseq_pkg::SARSEQ_CONVERT: begin
        d.cnt = q.cnt + 9'd1;
        if (q.cnt == total_len - 9'd1) begin
          conv_done = 1'b1;
        end
      end
      default: begin
        d.state = sarseq_pkg::SARSEQ_IDLE;
      end
    endcase
    if (conv_done) begin
      d.results[q.pos * 10 +: 10] = code;
      d.first = 1'b0;
      if (!q.scan_mode) begin
        d.convert_start_bit = 1'b0;
        d.conversion_end_flag = 1'b1;
        d.state = sarseq_pkg::SARSEQ_IDLE;
      end else begin
        if (q.pos == last_pos) begin
          d.conversion_end_flag = 1'b1;
          d.pos = 2'd0;
        end else begin
          d.pos = q.pos + 2'd1;
        end
        // later scan conversions skip sync, sampling starts at once
        d.state = sarseq_pkg::SARSEQ_SAMPLE;
        d.cnt = sync_len;
        d.sample_hold = 1'b1;
      end
    end
    if (stop_req) begin
      d.convert_start_bit = 1'b0;
      d.state = sarseq_pkg::SARSEQ_IDLE;
      d.sample_hold = 1'b0;
    end
    if (start_req) begin
      d.convert_start_bit = 1'b1;
      d.state = sarseq_pkg::SARSEQ_SYNC;
      d.cnt = 9'd0;
      d.first = 1'b1;
      d.pos = 2'd0;
      d.sample_hold = 1'b0;
    end
    // single mode converts the chosen input, scan walks from position 0
    if (d.scan_mode) begin
      d.analog_sel = {d.group_select_bit, d.pos};
    end else begin
      d.analog_sel = {d.group_select_bit, d.chan_select_hi, d.chan_select_lo};
      d.pos = {d.chan_select_hi, d.chan_select_lo};
    end
    d.irq = d.conversion_end_flag & d.conversion_irq_enable;
    // standby clears the block like reset
    if (standby) begin
      d = '0;
      d.ext_trigger_enable = sarseq_pkg::TRG_RESET[sarseq_pkg::TRG_EN_BIT];
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign rdata = q.rdata;
  assign conversion_end_irq = q.irq;
  assign analog_sel = q.analog_sel;
  assign sample_hold = q.sample_hold;
endmodule // sar_adc_sequencer
`default_nettype wire

// file: rtl/sarseq_pkg.sv
// sarseq_pkg: register map, field positions, reset values and state timing
// assumes one system clock; a "state" is one clock cycle of that clock
`default_nettype none
package sarseq_pkg;
  // register indices on the 8-bit cpu bus
  localparam logic [3:0] ADDR_RES_A_HI = 4'h0;
  localparam logic [3:0] ADDR_CSR = 4'h8;
  localparam logic [3:0] ADDR_TRG = 4'h9;
  // control/status field positions
  localparam int unsigned CSR_FLAG_BIT = 7;
  localparam int unsigned CSR_IE_BIT = 6;
  localparam int unsigned CSR_START_BIT = 5;
  localparam int unsigned CSR_SCAN_BIT = 4;
  localparam int unsigned CSR_CKS_BIT = 3;
  localparam int unsigned CSR_GROUP_BIT = 2;
  localparam int unsigned TRG_EN_BIT = 7;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] TRG_RESET = 8'h7F;
  localparam logic [6:0] TRG_RSVD_ONES = 7'h7F;
  // timing in states
  localparam int unsigned SYNC_SLOW_STATES = 10;
  localparam int unsigned SYNC_FAST_STATES = 6;
  localparam int unsigned SPL_SLOW_STATES = 80;
  localparam int unsigned SPL_FAST_STATES = 40;
  localparam int unsigned CONV_SLOW_MAX_STATES = 266;
  localparam int unsigned CONV_FAST_MAX_STATES = 134;
  localparam int unsigned SCAN_SLOW_STATES = 256;
  localparam int unsigned SCAN_FAST_STATES = 128;
  localparam int unsigned SYNC_SLOW_MAX = 17;
  localparam int unsigned SYNC_FAST_MAX = 9;
  // first conversion fixed at the top of its range (max delay used)
  localparam logic [8:0] FIRST_SLOW_CYC = 9'(CONV_SLOW_MAX_STATES);
  localparam logic [8:0] FIRST_FAST_CYC = 9'(CONV_FAST_MAX_STATES);
  localparam logic [8:0] NEXT_SLOW_CYC = 9'(SCAN_SLOW_STATES);
  localparam logic [8:0] NEXT_FAST_CYC = 9'(SCAN_FAST_STATES);
  localparam logic [8:0] SYNC_SLOW_CYC = 9'(SYNC_SLOW_MAX);
  localparam logic [8:0] SYNC_FAST_CYC = 9'(SYNC_FAST_MAX);
  localparam logic [8:0] SPL_SLOW_CYC = 9'(SPL_SLOW_STATES);
  localparam logic [8:0] SPL_FAST_CYC = 9'(SPL_FAST_STATES);
  typedef enum logic [1:0] {
    SARSEQ_IDLE = 2'b00,
    SARSEQ_SYNC = 2'b01,
    SARSEQ_SAMPLE = 2'b10,
    SARSEQ_CONVERT = 2'b11
  } sarseq_state_e;
endpackage
`default_nettype wire

// file: rtl/sarseq_sync.sv
// sarseq_sync: two-stage synchroniser plus falling-edge detect
// assumes d_in is asynchronous to clk
`default_nettype none
module sarseq_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic d_in,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sarseq_sync_s;
  sarseq_sync_s q, d;
  always_comb begin
    d.s1 = d_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end
  // idle level of the pin is high, so reset to ones avoids a false edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= 3'b111;
    end else begin
      q <= d;
    end
  end
  assign fall = q.s3 & ~q.s2;
endmodule // sarseq_sync
`default_nettype wire

// file: rtl/sarseq_sar.sv
// sarseq_sar: behavioural successive-approximation core
// assumes a comparator bit arrives each step; ten steps then done
`default_nettype none
module sarseq_sar (
  input wire logic clk,
  input wire logic resetn,
  input wire logic begin_conv,
  input wire logic step,
  input wire logic comp_in,
  output logic [9:0] code
);
  typedef struct packed {
    logic [9:0] code;
    logic [3:0] bit_idx;
  } sarseq_sar_s;
  sarseq_sar_s q, d;
  always_comb begin
    d = q;
    if (begin_conv) begin
      d.code = 10'h200;
      d.bit_idx = 4'h9;
    end else if (step && q.bit_idx != 4'hF) begin
      d.code[q.bit_idx] = comp_in;
      if (q.bit_idx != 4'h0) begin
        d.code[q.bit_idx - 4'h1] = 1'b1;
      end
      d.bit_idx = q.bit_idx - 4'h1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign code = q.code;
endmodule // sarseq_sar
`default_nettype wire

// file: tb/sarseq_assertions.sv
// sarseq_assertions: port-level checks of sar_adc_sequencer
// assumes rd and wr are one-cycle strobes taken on the rising clk edge
`default_nettype none
module sarseq_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic standby,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic ext_trigger_in_n,
  input wire logic comp_in,
  input wire logic [7:0] rdata,
  input wire logic conversion_end_irq,
  input wire logic [2:0] analog_sel,
  input wire logic sample_hold
);
  logic [7:0] spl_q;
  logic [7:0] spl_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  always_comb spl_d = sample_hold ? spl_q + 8'h01 : 8'h00;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) spl_q <= 8'h00;
    else spl_q <= spl_d;
  end
  trg_ones_a: assert property (rd && addr == 4'h9 |=> rdata[6:0] == 7'h7f)
    else $error("trigger low bits not ones");
  res_low_a: assert property (rd && !addr[3] && addr[0] |=> rdata[5:0] == 6'h00)
    else $error("result low bits not zero");
  rd_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data without read");
  // stops and standby cut the window short, so those are excluded
  spl_len_a: assert property ($fell(sample_hold) && !$past(standby) && !$past(wr)
    && !$past(wr, 2) |-> spl_q == 8'h50 || spl_q == 8'h28) else $error("bad sample length");
  spl_gap_a: assert property ($fell(sample_hold) |-> !sample_hold [*8])
    else $error("sampling restarted too soon");
  stby_clr_a: assert property (standby |=> !sample_hold && !conversion_end_irq)
    else $error("standby left activity");
  irq_mask_a: assert property (wr && addr == 4'h8 && !wdata[6] |-> ##[1:2]
    !conversion_end_irq) else $error("interrupt not masked");
  sel_hold_a: assert property (sample_hold ##1 sample_hold |-> $stable(analog_sel))
    else $error("input changed while sampling");
endmodule // sarseq_assertions
bind sar_adc_sequencer sarseq_assertions i_chk (.clk(clk), .resetn(resetn),
  .standby(standby), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
  .ext_trigger_in_n(ext_trigger_in_n), .comp_in(comp_in), .rdata(rdata),
  .conversion_end_irq(conversion_end_irq), .analog_sel(analog_sel),
  .sample_hold(sample_hold));
`default_nettype wire

// file: tb/sarseq_analog.sv
// sarseq_analog: comparator answer of eight fixed analog inputs
// assumes 1 means the input lies above every trial level
`default_nettype none
module sarseq_analog #(
  parameter logic [7:0] LEVELS = 8'hd2
) (
  input wire logic [2:0] analog_sel,
  output logic comp_in
);
  assign comp_in = LEVELS[analog_sel];
endmodule // sarseq_analog
`default_nettype wire

// file: tb/test_sar_adc_sequencer.sv
// test_sar_adc_sequencer: register-level tests of the converter sequencer
// assumes inputs 1, 4, 6, 7 read full scale and the others zero
`default_nettype none
module test_sar_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic standby = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic trg_n = 1'b1;
  logic comp_in;
  logic [7:0] rdata;
  logic irq;
  logic [2:0] analog_sel;
  logic sample_hold;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int t0;
  always #4 clk = ~clk;
  sar_adc_sequencer i_dut (.clk(clk), .resetn(resetn), .standby(standby), .addr(addr),
    .rd(rd), .wr(wr), .wdata(wdata), .ext_trigger_in_n(trg_n), .comp_in(comp_in),
    .rdata(rdata), .conversion_end_irq(irq), .analog_sel(analog_sel),
    .sample_hold(sample_hold));
  sarseq_analog i_ana (.analog_sel(analog_sel), .comp_in(comp_in));
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string what);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk(what, {8'h00, e}, {8'h00, rdata});
  endtask
  // bounded wait; n holds the cycles spent
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    rd_reg(4'h8, 8'h00, "csr reset");
    rd_reg(4'h9, 8'h7f, "trg reset");
    wr_reg(4'h9, 8'h00);
    rd_reg(4'h9, 8'h7f, "trg ro");
    $display("registers done");
    wr_reg(4'h8, 8'h61);
    rd_reg(4'h8, 8'h61, "busy");
    wait_irq;
    chk("slow time", 16'h0001, 16'(n >= 257 && n <= 267));
    wr_reg(4'h8, 8'h41);
    rd_reg(4'h8, 8'hc1, "flag kept");
    wr_reg(4'h8, 8'h41);
    rd_reg(4'h8, 8'h41, "flag clr");
    chk("irq off", 16'h0000, {15'h0000, irq});
    rd_reg(4'h2, 8'hff, "b hi");
    rd_reg(4'h3, 8'hc0, "b lo");
    $display("single done");
    wr_reg(4'h8, 8'h4f);
    trg_n = 1'b0;
    repeat (6) @(negedge clk);
    trg_n = 1'b1;
    rd_reg(4'h8, 8'h4f, "trg off");
    wr_reg(4'h9, 8'h80);
    rd_reg(4'h9, 8'hff, "trg on");
    trg_n = 1'b0;
    wait_irq;
    trg_n = 1'b1;
    chk("fast time", 16'h0001, 16'(n >= 129 && n <= 141));
    rd_reg(4'h8, 8'hcf, "trg end");
    rd_reg(4'h6, 8'hff, "d hi");
    rd_reg(4'h7, 8'hc0, "d lo");
    wr_reg(4'h8, 8'h4f);
    wr_reg(4'h9, 8'h00);
    $display("trigger done");
    wr_reg(4'h8, 8'h76);
    wait_irq;
    t0 = cyc;
    rd_reg(4'h8, 8'hf6, "scan flag");
    wr_reg(4'h8, 8'h76);
    wait_irq;
    chk("scan period", 16'd768, 16'(cyc - t0));
    wr_reg(4'h8, 8'h16);
    chk("masked", 16'h0000, {15'h0000, irq});
    rd_reg(4'h8, 8'h96, "scan stop");
    rd_reg(4'h0, 8'hff, "a hi");
    rd_reg(4'h2, 8'h00, "b hi");
    rd_reg(4'h4, 8'hff, "c hi");
    repeat (300) @(negedge clk);
    chk("idle", 16'h0000, {15'h0000, sample_hold});
    $display("scan done");
    wr_reg(4'h9, 8'h80);
    standby = 1'b1;
    repeat (2) @(negedge clk);
    standby = 1'b0;
    rd_reg(4'h8, 8'h00, "stby csr");
    rd_reg(4'h9, 8'h7f, "stby trg");
    rd_reg(4'h0, 8'h00, "stby res");
    $display("standby done");
    results();
  end
endmodule // test_sar_adc_sequencer
`default_nettype wire
